// File: tb/prsp_ext_proc.sv
`timescale 1ns/100ps
// ------
// External processor model
// ------
module prsp_ext_proc (
  // Clock
  input  wire logic                 ref_clk,
  // Pins
  input  wire prsp_pkg::prsp_byte_t pinLevel,
  output prsp_pkg::prsp_byte_t      drvData,
  output prsp_pkg::prsp_ctl_t       ctlDrv
);
  initial begin
    drvData = 8'h00;
    ctlDrv  = 3'h7;
  end

  // Released data lines flip to the inverse so a stale byte is never mistaken for a fresh one.
  task automatic wr_byte(input prsp_pkg::prsp_byte_t d);
    @(posedge ref_clk);
    drvData <= d;
    ctlDrv  <= 3'h1;
    repeat (6) @(posedge ref_clk);
    ctlDrv  <= 3'h7;
    drvData <= ~d;
    repeat (6) @(posedge ref_clk);
  endtask : wr_byte

  task automatic rd_byte(output prsp_pkg::prsp_byte_t d);
    @(posedge ref_clk);
    ctlDrv <= 3'h2;
    repeat (6) @(posedge ref_clk);
    d = pinLevel;
    ctlDrv <= 3'h7;
    repeat (6) @(posedge ref_clk);
  endtask : rd_byte
endmodule : prsp_ext_proc

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  // ------
  // Signals
  // ------
  logic                 ref_clk, reset, awvalid, wvalid, bready, arvalid, rready;
  logic                 awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp;
  prsp_pkg::prsp_word_t rdata;
  prsp_pkg::prsp_byte_t dataIn, dataOut, dataOe, drvData, pb;
  prsp_pkg::prsp_ctl_t  ctlIn, ctlOut, ctlOe, ctlDrv;
  int                   error_cnt, checks_done;

  // No pull-ups: an undriven pin shows what the far side puts there.
  assign dataIn = (dataOe & dataOut) | (~dataOe & drvData);
  assign ctlIn  = (ctlOe & ctlOut) | (~ctlOe & ctlDrv);

  prsp_slave_port prsp_slave_port_inst (.ref_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .dataIn,
    .dataOut, .dataOe, .ctlIn, .ctlOut, .ctlOe, .irq);
  prsp_ext_proc prsp_ext_proc_inst (.ref_clk, .pinLevel(dataIn), .drvData, .ctlDrv);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ------
  // Helpers
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge ref_clk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rchk

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    rchk(8'h00, 32'h0);
    rchk(8'h08, 32'h0);
    rchk(8'h0c, 32'h0);
    rchk(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h0, 2'h2);
  endtask : t_reset

  task automatic t_mode;
    wr(8'h14, 32'h7);
    wr(8'h00, 32'h1f);
    rchk(8'h00, 32'h10);
    chk({29'h0, ctlOe}, 32'h0);
  endtask : t_mode

  task automatic t_ext_write;
    prsp_ext_proc_inst.wr_byte(8'ha5);
    rchk(8'h00, 32'h90);
    rchk(8'h08, 32'h1);
    rchk(8'h04, 32'ha5);
    rchk(8'h00, 32'h10);
  endtask : t_ext_write

  task automatic t_overflow;
    prsp_ext_proc_inst.wr_byte(8'h11);
    prsp_ext_proc_inst.wr_byte(8'h22);
    rchk(8'h00, 32'hb0);
    wr(8'h00, 32'h30);
    rchk(8'h00, 32'hb0);
    rchk(8'h04, 32'h22);
    rchk(8'h00, 32'h30);
    wr(8'h00, 32'h10);
    rchk(8'h00, 32'h10);
  endtask : t_overflow

  task automatic t_ext_read;
    wr(8'h04, 32'h3c);
    rchk(8'h00, 32'h50);
    prsp_ext_proc_inst.rd_byte(pb);
    chk({24'h0, pb}, 32'h3c);
    rchk(8'h00, 32'h10);
    rchk(8'h08, 32'h7);
  endtask : t_ext_read

  // Interrupt lags status by a cycle, so each check waits two edges.
  task automatic t_irq;
    chk({31'h0, irq}, 32'h0);
    wr(8'h0c, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h08, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rchk(8'h08, 32'h5);
    wr(8'h0c, 32'h7);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h08, 32'h7);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_irq

  task automatic t_gpio;
    wr(8'h00, 32'h0);
    prsp_ext_proc_inst.wr_byte(8'h66);
    rchk(8'h00, 32'h0);
    rchk(8'h08, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h5a);
    repeat (2) @(posedge ref_clk);
    chk({24'h0, dataOe}, 32'hff);
    chk({24'h0, dataOut}, 32'h5a);
    rchk(8'h04, 32'h5a);
    // A write with lane 0 off must leave the direction register alone.
    wstrb <= 4'h0;
    wr(8'h10, 32'h55);
    wstrb <= 4'hf;
    rchk(8'h10, 32'h0);
    wr(8'h14, 32'h50);
    repeat (3) @(posedge ref_clk);
    chk({29'h0, ctlOe}, 32'h7);
    chk({29'h0, ctlOut}, 32'h5);
    rchk(8'h14, 32'h550);
  endtask : t_gpio

  initial begin
    reset       = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, arvalid} = '0;
    bready      = 1'b1;
    rready      = 1'b1;
    wstrb       = 4'hf;
    error_cnt   = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_mode;
    t_ext_write;
    t_overflow;
    t_ext_read;
    t_irq;
    t_gpio;
    complete_run;
  end

  // About forty transfers of at most twenty cycles each fit well inside this span.
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    complete_run;
  end
endmodule : testbench

// File: verilog/prsp_params.svh
`ifndef PRSP_PARAMS_SVH
`define PRSP_PARAMS_SVH
// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define PRSP_OFS_CTRL      8'h00
`define PRSP_OFS_DATA      8'h04
`define PRSP_OFS_IRQ_STAT  8'h08
`define PRSP_OFS_IRQ_MASK  8'h0c
`define PRSP_OFS_DATA_DIR  8'h10
`define PRSP_OFS_CTL_PINS  8'h14
// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define PRSP_BIT_IN_FULL   7
`define PRSP_BIT_OUT_FULL  6
`define PRSP_BIT_OVF       5
`define PRSP_BIT_MODE      4
`define PRSP_EV_WR         0
`define PRSP_EV_RD         1
`define PRSP_EV_OVF        2
`define PRSP_PIN_RD        0
`define PRSP_PIN_WR        1
`define PRSP_PIN_CS        2
`define PRSP_CTL_OUT_LSB   4
`define PRSP_CTL_IN_LSB    8
`define PRSP_UNIMPL_MSB    3
// ---------------------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------------------
`define PRSP_CTRL_RESET    8'h00
`define PRSP_DIR_RESET     8'hff
`define PRSP_CTLDIR_RESET  3'h7
`define PRSP_RESP_OKAY     2'h0
`define PRSP_RESP_SLVERR   2'h2
`endif

// File: verilog/prsp_pkg.sv
package prsp_pkg;
  typedef logic [7:0]  prsp_byte_t;
  typedef logic [2:0]  prsp_ctl_t;
  typedef logic [2:0]  prsp_event_t;
  typedef logic [31:0] prsp_word_t;
endpackage : prsp_pkg

// File: verilog/prsp_slave_port.sv
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - Mode select bit set turns the 8-bit data port into a slave port.
// - In slave mode the three control pins are inputs: read, write, select.
// - A write happens when select and write strobe are first seen low.
// - A read happens when select and read strobe are first seen low.
// - The external processor writes an 8-bit input latch and reads a separate 8-bit output latch asynchronously.
// - Output-full bit 6 is set by a CPU write in slave mode, cleared by external read.
// - Clearing mode select returns data and control pins to plain I/O.
// - The four low bits of the control register read as zero.
`include "prsp_params.svh"
module prsp_slave_port (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // AXI4-Lite write address and data
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // AXI4-Lite write response
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // AXI4-Lite read
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output prsp_pkg::prsp_word_t      rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // Data port pins
  input  wire prsp_pkg::prsp_byte_t dataIn,
  output prsp_pkg::prsp_byte_t      dataOut,
  output prsp_pkg::prsp_byte_t      dataOe,
  // Control pins: bit 2 select, bit 1 write strobe, bit 0 read strobe, all low active
  input  wire prsp_pkg::prsp_ctl_t  ctlIn,
  output prsp_pkg::prsp_ctl_t       ctlOut,
  output prsp_pkg::prsp_ctl_t       ctlOe,
  // Interrupt
  output logic                      irq
);
  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  prsp_pkg::prsp_byte_t dataS1_q, dataS2_q;
  prsp_pkg::prsp_ctl_t  ctlS1_q, ctlS2_q;
  logic                 wrActPrev_q, rdActPrev_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dataS1_q <= 8'h00;
      dataS2_q <= 8'h00;
      ctlS1_q  <= `PRSP_CTLDIR_RESET;
      ctlS2_q  <= `PRSP_CTLDIR_RESET;
    end else begin
      dataS1_q <= dataIn;
      dataS2_q <= dataS1_q;
      ctlS1_q  <= ctlIn;
      ctlS2_q  <= ctlS1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic                  mode_q, inFull_q, outFull_q, ovf_q;
  prsp_pkg::prsp_byte_t  inLatch_q, outLatch_q, dataDir_q;
  prsp_pkg::prsp_ctl_t   ctlDir_q, ctlLevel_q;
  prsp_pkg::prsp_event_t irqStat_q, irqMask_q;
  localparam prsp_pkg::prsp_byte_t CtrlReset = `PRSP_CTRL_RESET;

  // ---------------------------------------------------------------------------
  // Strobe decode
  // ---------------------------------------------------------------------------
  // Strobes are seen two cycles late; data passes the same two stages, so it lines up with the strobe edge.
  wire selLow  = ~ctlS2_q[`PRSP_PIN_CS];
  wire wrAct   = mode_q & selLow & ~ctlS2_q[`PRSP_PIN_WR];
  wire rdAct   = mode_q & selLow & ~ctlS2_q[`PRSP_PIN_RD];
  wire wrStart = wrAct & ~wrActPrev_q;
  wire rdStart = rdAct & ~rdActPrev_q;

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic       awGot_q, wGot_q, rdSelCtrl_q;
  logic [7:0] wAddr_q;
  logic [7:0] wByte_q;
  logic       wLane_q;

  wire awTake    = awvalid & awready;
  wire wTake     = wvalid & wready;
  wire arTake    = arvalid & arready;
  wire wrDo      = awGot_q & wGot_q & ~bvalid;
  wire wrHit     = wrDo & wLane_q;
  wire wCtrl     = wrHit & (wAddr_q == `PRSP_OFS_CTRL);
  wire wData     = wrHit & (wAddr_q == `PRSP_OFS_DATA);
  wire wStat     = wrHit & (wAddr_q == `PRSP_OFS_IRQ_STAT);
  wire wMask     = wrHit & (wAddr_q == `PRSP_OFS_IRQ_MASK);
  wire wDir      = wrHit & (wAddr_q == `PRSP_OFS_DATA_DIR);
  wire wCtlPins  = wrHit & (wAddr_q == `PRSP_OFS_CTL_PINS);
  wire wMapped   = (wAddr_q == `PRSP_OFS_CTRL) | (wAddr_q == `PRSP_OFS_DATA) |
                   (wAddr_q == `PRSP_OFS_IRQ_STAT) | (wAddr_q == `PRSP_OFS_IRQ_MASK) |
                   (wAddr_q == `PRSP_OFS_DATA_DIR) | (wAddr_q == `PRSP_OFS_CTL_PINS);
  wire rCtrl     = araddr == `PRSP_OFS_CTRL;
  wire rData     = araddr == `PRSP_OFS_DATA;
  wire rStat     = araddr == `PRSP_OFS_IRQ_STAT;
  wire rMask     = araddr == `PRSP_OFS_IRQ_MASK;
  wire rDir      = araddr == `PRSP_OFS_DATA_DIR;
  wire rCtlPins  = araddr == `PRSP_OFS_CTL_PINS;
  wire rMapped   = rCtrl | rData | rStat | rMask | rDir | rCtlPins;
  wire cpuDataRd = arTake & rData & mode_q;

  // Low nibble is tied off in the read word, so it always reads zero.
  wire prsp_pkg::prsp_byte_t ctrlView = {inFull_q, outFull_q, ovf_q, mode_q, 4'h0};
  wire prsp_pkg::prsp_byte_t dataView = mode_q ? inLatch_q : dataS2_q;
  wire prsp_pkg::prsp_word_t rdMux =
      rCtrl    ? {24'h000000, ctrlView} :
      rData    ? {24'h000000, dataView} :
      rStat    ? {29'h00000000, irqStat_q} :
      rMask    ? {29'h00000000, irqMask_q} :
      rDir     ? {24'h000000, dataDir_q} :
      rCtlPins ? {21'h000000, ctlS2_q, 1'b0, ctlLevel_q, 1'b0, ctlDir_q} : 32'h00000000;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      awGot_q     <= 1'b0;
      wGot_q      <= 1'b0;
      wAddr_q     <= 8'h00;
      wByte_q     <= 8'h00;
      wLane_q     <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= `PRSP_RESP_OKAY;
    end else begin
      if (awTake) begin
        awready <= 1'b0;
        awGot_q <= 1'b1;
        wAddr_q <= awaddr;
      end
      if (wTake) begin
        wready  <= 1'b0;
        wGot_q  <= 1'b1;
        wByte_q <= wdata[7:0];
        wLane_q <= wstrb[0];
      end
      if (wrDo) begin
        bvalid <= 1'b1;
        bresp  <= wMapped ? `PRSP_RESP_OKAY : `PRSP_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awGot_q <= 1'b0;
        wGot_q  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      arready     <= 1'b1;
      rvalid      <= 1'b0;
      rdata       <= 32'h00000000;
      rresp       <= `PRSP_RESP_OKAY;
      rdSelCtrl_q <= 1'b0;
    end else if (arTake) begin
      arready     <= 1'b0;
      rvalid      <= 1'b1;
      rdata       <= rdMux;
      rresp       <= rMapped ? `PRSP_RESP_OKAY : `PRSP_RESP_SLVERR;
      rdSelCtrl_q <= rCtrl;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Slave port flags and latches
  // ---------------------------------------------------------------------------
  // The last write wins: hardware sets beat same-cycle clears, except output-full, where the external read clear beats a CPU write.
  prsp_pkg::prsp_event_t evNow;
  assign evNow = {wrStart & inFull_q, rdStart, wrStart};

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wrActPrev_q <= 1'b0;
      rdActPrev_q <= 1'b0;
      mode_q      <= CtrlReset[`PRSP_BIT_MODE];
      inFull_q    <= 1'b0;
      outFull_q   <= 1'b0;
      ovf_q       <= 1'b0;
      inLatch_q   <= 8'h00;
      outLatch_q  <= 8'h00;
      dataDir_q   <= `PRSP_DIR_RESET;
      ctlDir_q    <= `PRSP_CTLDIR_RESET;
      ctlLevel_q  <= 3'h0;
      irqStat_q   <= 3'h0;
      irqMask_q   <= 3'h0;
    end else begin
      wrActPrev_q <= wrAct;
      rdActPrev_q <= rdAct;
      if (wCtrl) begin
        mode_q <= wByte_q[`PRSP_BIT_MODE];
        if (!wByte_q[`PRSP_BIT_OVF]) begin
          ovf_q <= 1'b0;
        end
      end
      if (wData) begin
        outLatch_q <= wByte_q;
        outFull_q  <= mode_q;
      end
      if (wDir) begin
        dataDir_q <= wByte_q;
      end
      if (wCtlPins) begin
        ctlDir_q   <= wByte_q[2:0];
        ctlLevel_q <= wByte_q[`PRSP_CTL_OUT_LSB +: 3];
      end
      if (wMask) begin
        irqMask_q <= wByte_q[2:0];
      end
      if (cpuDataRd) begin
        inFull_q <= 1'b0;
      end
      if (rdStart) begin
        outFull_q <= 1'b0;
      end
      if (wrStart) begin
        inLatch_q <= dataS2_q;
        inFull_q  <= 1'b1;
        if (inFull_q) begin
          ovf_q <= 1'b1;
        end
      end
      irqStat_q <= (irqStat_q & ~(wStat ? wByte_q[2:0] : 3'h0)) | evNow;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drivers and interrupt
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dataOut <= 8'h00;
      dataOe  <= 8'h00;
      ctlOut  <= 3'h0;
      ctlOe   <= 3'h0;
      irq     <= 1'b0;
    end else begin
      dataOut <= outLatch_q;
      dataOe  <= mode_q ? {8{rdAct}} : ~dataDir_q;
      ctlOut  <= ctlLevel_q;
      ctlOe   <= mode_q ? 3'h0 : ~ctlDir_q;
      irq     <= |(irqStat_q & irqMask_q);
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_mode_gates_strobes: assert property (@(posedge ref_clk) disable iff (reset)
    !mode_q |=> $stable(inFull_q) && $stable(inLatch_q)) else $error("strobe seen outside slave mode");
  chk_ctl_pins_input: assert property (@(posedge ref_clk) disable iff (reset)
    mode_q ##1 mode_q |-> ctlOe == 3'h0) else $error("control pin driven in slave mode");
  chk_write_captures: assert property (@(posedge ref_clk) disable iff (reset)
    wrStart |=> inFull_q && inLatch_q == $past(dataS2_q)) else $error("external write lost");
  chk_read_empties: assert property (@(posedge ref_clk) disable iff (reset)
    rdStart && !wData |=> !outFull_q) else $error("external read left output full");
  chk_read_drives_bus: assert property (@(posedge ref_clk) disable iff (reset)
    rdAct |=> dataOe == 8'hff && dataOut == $past(outLatch_q)) else $error("read data not driven");
  chk_cpu_fills_out: assert property (@(posedge ref_clk) disable iff (reset)
    wData && mode_q && !rdStart |=> outFull_q ##0 outLatch_q == $past(wByte_q)) else $error("output full not set");
  chk_gpio_restores: assert property (@(posedge ref_clk) disable iff (reset)
    !mode_q |=> dataOe == ~$past(dataDir_q) && ctlOe == ~$past(ctlDir_q)) else $error("pins not plain I/O");
  chk_unimpl_zero: assert property (@(posedge ref_clk) disable iff (reset)
    rvalid && rdSelCtrl_q |-> rdata[`PRSP_UNIMPL_MSB:0] == 4'h0) else $error("low nibble not zero");
  chk_cpu_read_clears: assert property (@(posedge ref_clk) disable iff (reset)
    cpuDataRd && !wrStart |=> !inFull_q) else $error("input full not cleared");
  chk_overflow_sticky: assert property (@(posedge ref_clk) disable iff (reset)
    (wrStart && inFull_q) or (ovf_q && !(wCtrl && !wByte_q[`PRSP_BIT_OVF])) |=> ovf_q)
    else $error("overflow flag dropped");
  chk_read_releases: assert property (@(posedge ref_clk) disable iff (reset)
    mode_q && !rdAct |=> dataOe == 8'h00) else $error("data port driven without a read");
  chk_overflow_sets: assert property (@(posedge ref_clk) disable iff (reset)
    wrStart && inFull_q |=> ovf_q && irqStat_q[`PRSP_EV_OVF]) else $error("overflow not flagged");
  chk_overflow_clears: assert property (@(posedge ref_clk) disable iff (reset)
    wCtrl && !wByte_q[`PRSP_BIT_OVF] && !wrStart |=> !ovf_q) else $error("overflow not cleared");
  chk_write_event: assert property (@(posedge ref_clk) disable iff (reset)
    wrStart |=> irqStat_q[`PRSP_EV_WR]) else $error("write event not flagged");
  chk_read_event: assert property (@(posedge ref_clk) disable iff (reset)
    rdStart |=> irqStat_q[`PRSP_EV_RD]) else $error("read event not flagged");
endmodule : prsp_slave_port
